// ### atr_pkg.sv
// constants shared by the angle and turns readout register block
package atr_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_FIELD_STRENGTH = 10'h02A;
    localparam logic [IDX_W-1:0] IDX_TURNS_COUNT = 10'h02C;
    localparam logic [IDX_W-1:0] IDX_TURNS_OFFSET_SNAPSHOT = 10'h02E;
    localparam logic [IDX_W-1:0] IDX_ANGLE_WITH_HYSTERESIS = 10'h030;
    localparam logic [IDX_W-1:0] IDX_ANGLE_FINE = 10'h032;
    localparam logic [IDX_W-1:0] IDX_ZERO_CROSS_ANGLE = 10'h034;
    localparam logic [IDX_W-1:0] IDX_TURNS_DELTA_UPPER = 10'h036;
    localparam logic [IDX_W-1:0] IDX_TURNS_DELTA_LOWER = 10'h038;
    localparam logic [IDX_W-1:0] IDX_TURNS_PATH_ANGLE = 10'h03A;
    localparam logic [IDX_W-1:0] IDX_UNLOCK_KEY = 10'h03C;
    localparam logic [IDX_W-1:0] IDX_FAULT_STATUS = 10'h040;
    localparam logic [IDX_W-1:0] IDX_FAULT_MASK = 10'h041;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PAR_BIT = 12;
    localparam int UV_BIT = 13;
    localparam int EF_BIT = 14;
    localparam int SRC_SEL_BIT = 13;
    localparam int OFF_LAT_BIT = 14;
    localparam int LOW_LAT_BIT = 13;
    localparam int SRC_IND_BIT = 14;
    localparam int UNLOCK_BIT = 0;
    localparam int KEY_LSB = 8;
    localparam int WARN_LSB = 16;
    localparam logic [31:0] FAULT_BITS = 32'h0FFF_0FFF;

    // ------------------------------------------------------------
    // reset values, codes and bus answers
    // ------------------------------------------------------------
    localparam logic SRC_SEL_RST = 1'b1;
    localparam logic [31:0] UNLOCK_CODE = 32'h2781_1F77;
    localparam logic [31:0] FAULT_MASK_RST = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : atr_pkg

// ### atr_readout_regs.sv
// axi4-lite register block presenting sensor angle, turns and field readouts
`timescale 1ns/10ps

// Overview of operation
// RQ1: field word shows coarse 12-bit gauss value.
// RQ2: turns word shows signed 12-bit step count.
// RQ3: turns read captures offset, sets its latched indicator.
// RQ4: bit 12 gives parity words odd ones.
// RQ5: select bit: 1 locked loop, 0 zero crossing.
// RQ6: offset is 11 delta LSBs at 180, 9 at 45 degrees.
// RQ7: offset indicator clears after offset read.
// RQ8: hysteretic angle word shows unsigned 12-bit angle.
// RQ9: angle word bit 13 is live masked undervoltage.
// RQ10: bit 14 set while any unmasked fault is set.
// RQ11: fine angle word shows 15 unrounded bits.
// RQ12: zero-cross word shows unsigned 12-bit angle.
// RQ13: upper delta word: upper 9 bits sign-extended to 12.
// RQ14: upper delta read captures lower word, sets indicator.
// RQ15: lower delta word holds lower 12 delta bits.
// RQ16: lower indicator clears after lower read.
// RQ17: upper delta bit 14 shows the turns source.
// RQ18: turns path word shows unsigned 12-bit angle.
// RQ19: key bit 0 reads one while unlocked.
// RQ20: keycode byte takes unlock code, reads zero.
// RQ21: fault bits stay set until cleared.
// RQ22: unlock only after four code bytes in order.
module atr_readout_regs
    import atr_pkg::*;
#(
    parameter int AW = 12
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [11:0] field_gauss_i,
    input wire logic [11:0] turns_i,
    input wire logic turns_45deg_i,
    input wire logic [20:0] turns_delta_i,
    input wire logic [11:0] angle_hysteretic_i,
    input wire logic [14:0] angle_fine_i,
    input wire logic [11:0] zero_cross_angle_value_i,
    input wire logic [11:0] turns_path_angle_i,
    input wire logic uv_analog_i,
    input wire logic uv_digital_i,
    input wire logic uv_analog_mask_i,
    input wire logic uv_digital_mask_i,
    input wire logic [11:0] err_event_i,
    input wire logic [11:0] warn_event_i,
    output logic rotation_source_select_o,
    output logic customer_unlocked_o,
    output logic error_summary_flag_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [IDX_W-1:0] ridx;
        logic aw_have;
        logic w_have;
        logic [IDX_W-1:0] awidx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic src_sel;
        logic [10:0] off_val;
        logic off_lat;
        logic [11:0] low_val;
        logic low_lat;
        logic [1:0] key_pos;
        logic unlocked;
        logic [31:0] fault_sts;
        logic [31:0] fault_msk;
        logic err_flag;
    } atr_state_t;

    atr_state_t st_reg;
    atr_state_t st_next;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_do;
    logic uv_live;
    logic ef_live;
    logic [IDX_W-1:0] ar_idx;
    logic [31:0] fault_clr;
    logic [7:0] key_byte;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // fills bit 12 so the 16-bit word carries an odd number of ones
    function automatic logic [15:0] odd_par(input logic [15:0] w);
        logic [15:0] r;
        r = w;
        r[PAR_BIT] = 1'b0;
        r[PAR_BIT] = ~(^r);
        return r;
    endfunction : odd_par

    // widens the byte strobes into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : lane_mask

    // words whose bit 12 is a parity bit
    function automatic logic has_par(input logic [IDX_W-1:0] i);
        return (i == IDX_TURNS_COUNT) || (i == IDX_TURNS_OFFSET_SNAPSHOT)
            || (i == IDX_ANGLE_WITH_HYSTERESIS) || (i == IDX_ZERO_CROSS_ANGLE)
            || (i == IDX_TURNS_DELTA_UPPER) || (i == IDX_TURNS_DELTA_LOWER)
            || (i == IDX_TURNS_PATH_ANGLE);
    endfunction : has_par

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // handshakes use registered readies, so no combinational path crosses the bus
    always_comb
    begin
        st_next = st_reg;
        aw_fire = s_axi_awvalid_i && st_reg.awready;
        w_fire = s_axi_wvalid_i && st_reg.wready;
        ar_fire = s_axi_arvalid_i && st_reg.arready;
        ar_idx = s_axi_araddr_i[AW-1:2];
        wr_do = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
        fault_clr = 32'h0000_0000;
        key_byte = st_reg.wdata[KEY_LSB +: 8];
        // masked live undervoltage, not latched
        uv_live = (uv_analog_i && !uv_analog_mask_i)
            || (uv_digital_i && !uv_digital_mask_i); // RQ9
        ef_live = |(st_reg.fault_sts & ~st_reg.fault_msk); // RQ10

        // write address and data are taken independently, in either order
        if (aw_fire)
        begin
            st_next.aw_have = 1'b1;
            st_next.awidx = s_axi_awaddr_i[AW-1:2];
        end
        if (w_fire)
        begin
            st_next.w_have = 1'b1;
            st_next.wdata = s_axi_wdata_i;
            st_next.wstrb = s_axi_wstrb_i;
        end

        // write action once both halves are held
        if (wr_do)
        begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            case (st_reg.awidx)
                IDX_TURNS_COUNT:
                begin
                    if (st_reg.wstrb[1])
                    begin
                        st_next.src_sel = st_reg.wdata[SRC_SEL_BIT]; // RQ5
                    end
                end
                IDX_UNLOCK_KEY:
                begin
                    // a wrong byte restarts the sequence, a first byte may reopen it
                    if (st_reg.wstrb[1])
                    begin
                        if (key_byte == UNLOCK_CODE[8*(3-st_reg.key_pos) +: 8])
                        begin
                            st_next.key_pos = st_reg.key_pos + 2'd1; // RQ22
                            if (st_reg.key_pos == 2'd3)
                            begin
                                st_next.unlocked = 1'b1; // RQ22
                            end
                        end
                        else if (key_byte == UNLOCK_CODE[31:24])
                        begin
                            st_next.key_pos = 2'd1;
                        end
                        else
                        begin
                            st_next.key_pos = 2'd0;
                        end
                    end
                end
                IDX_FAULT_STATUS:
                begin
                    fault_clr = st_reg.wdata & lane_mask(st_reg.wstrb); // RQ21
                end
                IDX_FAULT_MASK:
                begin
                    st_next.fault_msk = ((st_reg.fault_msk & ~lane_mask(st_reg.wstrb))
                        | (st_reg.wdata & lane_mask(st_reg.wstrb))) & FAULT_BITS;
                end
                IDX_FIELD_STRENGTH, IDX_TURNS_OFFSET_SNAPSHOT, IDX_ANGLE_WITH_HYSTERESIS,
                IDX_ANGLE_FINE, IDX_ZERO_CROSS_ANGLE, IDX_TURNS_DELTA_UPPER,
                IDX_TURNS_DELTA_LOWER, IDX_TURNS_PATH_ANGLE:
                begin
                    // read-only words ignore writes
                end
                default:
                begin
                    st_next.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.bvalid && s_axi_bready_i)
        begin
            st_next.bvalid = 1'b0;
        end

        // read: data sampled at the address handshake, with its side effects
        if (ar_fire)
        begin
            st_next.rvalid = 1'b1;
            st_next.ridx = ar_idx;
            st_next.rresp = RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            case (ar_idx)
                IDX_FIELD_STRENGTH:
                begin
                    st_next.rdata[11:0] = field_gauss_i; // RQ1
                end
                IDX_TURNS_COUNT:
                begin
                    st_next.rdata[15:0] = odd_par({2'b00, st_reg.src_sel, 1'b0, turns_i}); // RQ2 RQ4
                    // offset taken at the same edge as the count
                    st_next.off_val = turns_45deg_i ? {2'b00, turns_delta_i[8:0]}
                        : turns_delta_i[10:0]; // RQ3 RQ6
                    st_next.off_lat = 1'b1; // RQ3
                end
                IDX_TURNS_OFFSET_SNAPSHOT:
                begin
                    st_next.rdata[15:0] = odd_par({1'b0, st_reg.off_lat, 3'b000,
                        st_reg.off_val}); // RQ4 RQ7
                    st_next.off_lat = 1'b0; // RQ7
                end
                IDX_ANGLE_WITH_HYSTERESIS:
                begin
                    st_next.rdata[15:0] = odd_par({1'b0, ef_live, uv_live, 1'b0,
                        angle_hysteretic_i}); // RQ8
                end
                IDX_ANGLE_FINE:
                begin
                    st_next.rdata[14:0] = angle_fine_i; // RQ11
                end
                IDX_ZERO_CROSS_ANGLE:
                begin
                    st_next.rdata[15:0] = odd_par({1'b0, ef_live, uv_live, 1'b0,
                        zero_cross_angle_value_i}); // RQ12
                end
                IDX_TURNS_DELTA_UPPER:
                begin
                    st_next.rdata[15:0] = odd_par({1'b0, st_reg.src_sel, 2'b00,
                        {3{turns_delta_i[20]}}, turns_delta_i[20:12]}); // RQ13 RQ17
                    st_next.low_val = turns_delta_i[11:0]; // RQ14
                    st_next.low_lat = 1'b1; // RQ14
                end
                IDX_TURNS_DELTA_LOWER:
                begin
                    st_next.rdata[15:0] = odd_par({1'b0, ef_live, st_reg.low_lat, 1'b0,
                        st_reg.low_val}); // RQ15 RQ16
                    st_next.low_lat = 1'b0; // RQ16
                end
                IDX_TURNS_PATH_ANGLE:
                begin
                    st_next.rdata[15:0] = odd_par({1'b0, ef_live, uv_live, 1'b0,
                        turns_path_angle_i}); // RQ18
                end
                IDX_UNLOCK_KEY:
                begin
                    // keycode byte never echoes what was entered
                    st_next.rdata[UNLOCK_BIT] = st_reg.unlocked; // RQ19 RQ20
                end
                IDX_FAULT_STATUS:
                begin
                    st_next.rdata = st_reg.fault_sts;
                end
                IDX_FAULT_MASK:
                begin
                    st_next.rdata = st_reg.fault_msk;
                end
                default:
                begin
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.rvalid && s_axi_rready_i)
        begin
            st_next.rvalid = 1'b0;
        end

        // sticky faults: a new event wins over a clear in the same cycle
        st_next.fault_sts = ((st_reg.fault_sts & ~fault_clr)
            | {4'h0, warn_event_i, 4'h0, err_event_i}) & FAULT_BITS; // RQ21
        st_next.err_flag = ef_live; // RQ10

        // one write and one read in flight; readies drop while holding
        st_next.awready = !st_next.aw_have && !st_next.bvalid;
        st_next.wready = !st_next.w_have && !st_next.bvalid;
        st_next.arready = !st_next.rvalid;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
            st_reg.src_sel <= SRC_SEL_RST;
            st_reg.fault_msk <= FAULT_MASK_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready_o = st_reg.awready;
    assign s_axi_wready_o = st_reg.wready;
    assign s_axi_bvalid_o = st_reg.bvalid;
    assign s_axi_bresp_o = st_reg.bresp;
    assign s_axi_arready_o = st_reg.arready;
    assign s_axi_rvalid_o = st_reg.rvalid;
    assign s_axi_rresp_o = st_reg.rresp;
    assign s_axi_rdata_o = st_reg.rdata;
    assign rotation_source_select_o = st_reg.src_sel;
    assign customer_unlocked_o = st_reg.unlocked;
    assign error_summary_flag_o = st_reg.err_flag;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_off_capture: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ3
        ar_fire && ar_idx == IDX_TURNS_COUNT |=> st_reg.off_lat
            && st_reg.off_val == ($past(turns_45deg_i) ? {2'b00, $past(turns_delta_i[8:0])}
            : $past(turns_delta_i[10:0])))
        else $error("turns read did not capture offset");

    a_off_lat_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ7
        ar_fire && ar_idx == IDX_TURNS_OFFSET_SNAPSHOT |=> !st_reg.off_lat
            && s_axi_rvalid_o && s_axi_rdata_o[OFF_LAT_BIT] == $past(st_reg.off_lat))
        else $error("offset indicator not shown then cleared");

    a_low_capture: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ14
        ar_fire && ar_idx == IDX_TURNS_DELTA_UPPER |=> st_reg.low_lat
            && st_reg.low_val == $past(turns_delta_i[11:0]))
        else $error("upper delta read did not capture lower word");

    a_low_lat_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ16
        ar_fire && ar_idx == IDX_TURNS_DELTA_LOWER |=> !st_reg.low_lat
            && s_axi_rdata_o[LOW_LAT_BIT] == $past(st_reg.low_lat))
        else $error("lower indicator not shown then cleared");

    a_parity_odd: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ4
        s_axi_rvalid_o && s_axi_rresp_o == RESP_OKAY && has_par(st_reg.ridx)
            |-> ^s_axi_rdata_o[15:0])
        else $error("readout word parity is not odd");

    a_key_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ20
        s_axi_rvalid_o && st_reg.ridx == IDX_UNLOCK_KEY
            |-> s_axi_rdata_o[15:KEY_LSB] == 8'h00)
        else $error("keycode byte read back nonzero");

    a_unlock_seq: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ22
        $rose(customer_unlocked_o) |-> $past(st_reg.key_pos) == 2'd3
            && $past(key_byte) == UNLOCK_CODE[7:0])
        else $error("unlock without full code sequence");

    a_fault_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ21
        !(wr_do && st_reg.awidx == IDX_FAULT_STATUS)
            |=> (st_reg.fault_sts & $past(st_reg.fault_sts)) == $past(st_reg.fault_sts))
        else $error("fault bit dropped without a clear");

    a_ef_follows: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ10
        ##1 (|(st_reg.fault_sts & ~st_reg.fault_msk)) |=> error_summary_flag_o)
        else $error("error summary missed an unmasked fault");

endmodule : atr_readout_regs

// ### atr_host_model.sv
// axi4-lite host model issuing single register reads and writes
`timescale 1ns/10ps
module atr_host_model
(
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic aw_rdy_i,
    input wire logic w_rdy_i,
    input wire logic [1:0] b_resp_i,
    input wire logic b_vld_i,
    input wire logic ar_rdy_i,
    input wire logic [31:0] r_data_i,
    input wire logic [1:0] r_resp_i,
    input wire logic r_vld_i,
    output logic [11:0] aw_addr_o,
    output logic aw_vld_o,
    output logic [31:0] w_data_o,
    output logic [3:0] w_strb_o,
    output logic w_vld_o,
    output logic b_rdy_o,
    output logic [11:0] ar_addr_o,
    output logic ar_vld_o,
    output logic r_rdy_o,
    output logic hung_o
);
    // ----------------------------------------
    // idle bus
    // ----------------------------------------
    initial
    begin
        {aw_addr_o, aw_vld_o, w_data_o, w_strb_o, w_vld_o} = '0;
        {b_rdy_o, ar_addr_o, ar_vld_o, r_rdy_o, hung_o} = '0;
    end

    // released payload is inverted so a stale value never looks valid
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        int n;
        bit ad;
        bit wd;
        @(posedge clk_i);
        {aw_addr_o, w_data_o, w_strb_o, aw_vld_o, w_vld_o} <= {a, d, s, 2'b11};
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        do
        begin
            @(posedge clk_i);
            n++;
            if (!ad && aw_rdy_i === 1'b1)
            begin
                ad = 1'b1;
                {aw_vld_o, aw_addr_o} <= {1'b0, ~a};
            end
            if (!wd && w_rdy_i === 1'b1)
            begin
                wd = 1'b1;
                {w_vld_o, w_data_o} <= {1'b0, ~d};
            end
        end
        while (!(ad && wd) && n < 64);
        // slow mode lets the response stand a few cycles
        if (slow_i)
            repeat (3) @(posedge clk_i);
        b_rdy_o <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (b_vld_i !== 1'b1 && n < 128);
        r = b_resp_i;
        b_rdy_o <= 1'b0;
        hung_o = hung_o | (n >= 128);
    endtask : wr

    // single read, data taken at the handshake edge
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_i);
        {ar_addr_o, ar_vld_o} <= {a, 1'b1};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ar_rdy_i !== 1'b1 && n < 64);
        {ar_vld_o, ar_addr_o} <= {1'b0, ~a};
        if (slow_i)
            repeat (3) @(posedge clk_i);
        r_rdy_o <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (r_vld_i !== 1'b1 && n < 128);
        d = r_data_i;
        r = r_resp_i;
        r_rdy_o <= 1'b0;
        hung_o = hung_o | (n >= 128);
    endtask : rd
endmodule : atr_host_model

// ### atr_readout_regs_bench.sv
// self-checking bench for the angle and turns readout registers
`timescale 1ns/10ps
module atr_readout_regs_bench
    import atr_pkg::*;
;
    typedef struct packed {
        logic [9:0] idx;
        logic [14:0] v;
        logic [15:0] base;
        logic p;
        logic [1:0] resp;
    } atr_row_t;
    logic sys_clk_i, rst_i = 1'b1, slow = 1'b0, turns_45deg_i = 1'b0;
    logic [11:0] s_axi_awaddr_i, s_axi_araddr_i, field_gauss_i = 12'h000, turns_i = 12'h000;
    logic [11:0] angle_hysteretic_i = 12'h000, zero_cross_angle_value_i = 12'h000;
    logic [11:0] turns_path_angle_i = 12'h000, err_event_i = 12'h000, warn_event_i = 12'h000;
    logic [14:0] angle_fine_i = 15'h0000;
    logic [20:0] turns_delta_i = 21'h00_0000;
    logic uv_analog_i = 1'b0, uv_digital_i = 1'b0, uv_analog_mask_i = 1'b0;
    logic uv_digital_mask_i = 1'b0;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
    logic rotation_source_select_o, customer_unlocked_o, error_summary_flag_o;
    int bad_count = 0, checked = 0;
    atr_row_t rows [9];
    logic [7:0] keys [6];

    atr_readout_regs atr_readout_regs_i (.*);
    atr_host_model atr_host_model_i (.clk_i(sys_clk_i), .slow_i(slow),
        .aw_rdy_i(s_axi_awready_o), .w_rdy_i(s_axi_wready_o), .b_resp_i(s_axi_bresp_o),
        .b_vld_i(s_axi_bvalid_o), .ar_rdy_i(s_axi_arready_o), .r_data_i(s_axi_rdata_o),
        .r_resp_i(s_axi_rresp_o), .r_vld_i(s_axi_rvalid_o), .aw_addr_o(s_axi_awaddr_i),
        .aw_vld_o(s_axi_awvalid_i), .w_data_o(s_axi_wdata_i), .w_strb_o(s_axi_wstrb_i),
        .w_vld_o(s_axi_wvalid_i), .b_rdy_o(s_axi_bready_i), .ar_addr_o(s_axi_araddr_i),
        .ar_vld_o(s_axi_arvalid_i), .r_rdy_o(s_axi_rready_i), .hung_o());

    // ----------------------------------------
    // clock and helpers
    // ----------------------------------------
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // bit 12 makes the 16-bit word odd
    function automatic logic [31:0] par(input logic [15:0] w);
        par = {16'h0000, w[15:13], ~^{w[15:13], w[11:0]}, w[11:0]};
    endfunction : par

    task automatic summarize();
        if (atr_host_model_i.hung_o === 1'b1)
            bad_count++;
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic rd(input logic [9:0] idx);
        atr_host_model_i.rd({idx, 2'b00}, d, resp);
        if (atr_host_model_i.hung_o === 1'b1)
            summarize();
    endtask : rd

    task automatic wr(input logic [9:0] idx, input logic [31:0] v, input logic [3:0] s);
        atr_host_model_i.wr({idx, 2'b00}, v, s, resp);
        if (atr_host_model_i.hung_o === 1'b1)
            summarize();
    endtask : wr

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rows = '{'{IDX_FIELD_STRENGTH, 15'h0ABC, 16'h0ABC, 1'b0, RESP_OKAY},
            '{IDX_ANGLE_FINE, 15'h7FFF, 16'h7FFF, 1'b0, RESP_OKAY},
            '{IDX_ANGLE_WITH_HYSTERESIS, 15'h0003, 16'h0003, 1'b1, RESP_OKAY},
            '{IDX_ANGLE_WITH_HYSTERESIS, 15'h0001, 16'h0001, 1'b1, RESP_OKAY},
            '{IDX_ZERO_CROSS_ANGLE, 15'h0800, 16'h0800, 1'b1, RESP_OKAY},
            '{IDX_TURNS_PATH_ANGLE, 15'h0FFF, 16'h0FFF, 1'b1, RESP_OKAY},
            '{IDX_TURNS_COUNT, 15'h0F85, 16'h2F85, 1'b1, RESP_OKAY},
            '{IDX_UNLOCK_KEY, 15'h0000, 16'h0000, 1'b0, RESP_OKAY},
            '{10'h3FF, 15'h0000, 16'h0000, 1'b0, RESP_SLVERR}};
        keys = '{UNLOCK_CODE[31:24], 8'h55, UNLOCK_CODE[31:24], UNLOCK_CODE[23:16],
            UNLOCK_CODE[15:8], UNLOCK_CODE[7:0]};
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        chk("sel_rst", 32'h1, rotation_source_select_o);
        chk("unl_rst", 32'h0, {customer_unlocked_o, error_summary_flag_o});
        // one value on the field, turns and angle inputs
        foreach (rows[k])
        begin
            {field_gauss_i, turns_i, angle_hysteretic_i} <= {3{rows[k].v[11:0]}};
            {zero_cross_angle_value_i, turns_path_angle_i} <= {2{rows[k].v[11:0]}};
            angle_fine_i <= rows[k].v;
            rd(rows[k].idx);
            chk("row", rows[k].p ? par(rows[k].base) : {16'h0000, rows[k].base}, d);
            chk("row_resp", rows[k].resp, resp);
        end
        // snapshot outlives a delta change
        slow <= 1'b1;
        turns_delta_i <= 21'h1A_BCDF;
        rd(IDX_TURNS_COUNT);
        turns_delta_i <= 21'h00_0000;
        rd(IDX_TURNS_OFFSET_SNAPSHOT);
        chk("offset", par(16'h44DF), d);
        rd(IDX_TURNS_OFFSET_SNAPSHOT);
        chk("off_lat", 32'h0, d[OFF_LAT_BIT]);
        turns_45deg_i <= 1'b1;
        turns_delta_i <= 21'h00_07FF;
        rd(IDX_TURNS_COUNT);
        rd(IDX_TURNS_OFFSET_SNAPSHOT);
        chk("offset45", par(16'h41FF), d);
        slow <= 1'b0;
        turns_45deg_i <= 1'b0;
        turns_delta_i <= 21'h10_0123;
        rd(IDX_TURNS_DELTA_UPPER);
        chk("upper", par(16'h4F00), d);
        turns_delta_i <= 21'h00_0000;
        rd(IDX_TURNS_DELTA_LOWER);
        chk("lower", par(16'h2123), d);
        rd(IDX_TURNS_DELTA_LOWER);
        chk("low_lat", 32'h0, d[LOW_LAT_BIT]);
        wr(IDX_TURNS_COUNT, 32'h0000_0000, 4'b0010);
        chk("sel", 32'h0, rotation_source_select_o);
        rd(IDX_TURNS_DELTA_UPPER);
        chk("src", 32'h0, d[SRC_IND_BIT]);
        wr(IDX_TURNS_COUNT, 32'h0000_2000, 4'b0010);
        // every undervoltage and mask combination
        for (int i = 0; i < 16; i++)
        begin
            {uv_analog_i, uv_analog_mask_i, uv_digital_i, uv_digital_mask_i} <= i[3:0];
            rd(IDX_TURNS_PATH_ANGLE);
            chk("uv", (i[3] & ~i[2]) | (i[1] & ~i[0]), d[UV_BIT]);
        end
        // one-cycle fault pulses must stick
        {err_event_i, warn_event_i} <= {12'h008, 12'h001};
        @(posedge sys_clk_i);
        {err_event_i, warn_event_i} <= 24'h00_0000;
        repeat (3) @(posedge sys_clk_i);
        chk("ef", 32'h1, error_summary_flag_o);
        rd(IDX_FAULT_STATUS);
        chk("status", 32'h0001_0008, d);
        rd(IDX_ZERO_CROSS_ANGLE);
        chk("ef_word", 32'h1, d[EF_BIT]);
        wr(IDX_FAULT_MASK, 32'h0001_0008, 4'hF);
        repeat (3) @(posedge sys_clk_i);
        chk("ef_mask", 32'h0, error_summary_flag_o);
        wr(IDX_FAULT_STATUS, 32'h0000_0008, 4'hF);
        rd(IDX_FAULT_STATUS);
        chk("w1c", 32'h0001_0000, d);
        // wrong byte restarts the sequence, unlock only on the last byte
        foreach (keys[k])
        begin
            wr(IDX_UNLOCK_KEY, {16'h0000, keys[k], 8'h00}, 4'b0010);
            chk("unlock", k == 5, customer_unlocked_o);
        end
        rd(IDX_UNLOCK_KEY);
        chk("key", 32'h0000_0001, d);
        wr(10'h3FF, 32'h0000_0000, 4'hF);
        chk("wr_unmapped", RESP_SLVERR, resp);
        summarize();
    end
endmodule : atr_readout_regs_bench
